// >>> include/pei_pkg.sv
/*
  Constants of the port edge interrupt and key-scan access block:
  system register addresses, field positions and reset values.
  Assumes a 4-bit system register space with 6-bit addresses.
*/
package pei_pkg;

  // Bus widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 4;
  localparam int PORT_W = 4;
  localparam int NUM_PORTS = 6;
  localparam int PIN_W = PORT_W * NUM_PORTS;

  // Register addresses
  localparam logic [5:0] ADDR_PORT_MODE = 6'h15;
  localparam logic [5:0] ADDR_ACCESS_CDEF = 6'h1C;
  localparam logic [5:0] ADDR_ACCESS_AB = 6'h1D;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h30;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h31;
  localparam logic [5:0] ADDR_SEG_SELECT = 6'h32;
  localparam logic [5:0] ADDR_ALT_FUNC = 6'h33;

  // Port mode register fields
  localparam int PULL_ENABLE_BIT = 3;
  localparam int PULL_DIR_BIT = 2;

  // Access register fields (first register: C D E F in bits 3..0)
  localparam int ACC_C_BIT = 3;
  localparam int ACC_D_BIT = 2;
  localparam int ACC_E_BIT = 1;
  localparam int ACC_F_BIT = 0;
  localparam int ACC_A_BIT = 1;
  localparam int ACC_B_BIT = 0;

  // Port indices within the pin vectors
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;

  // Interrupt status and mask fields
  localparam int IRQ_GROUP_BIT = 0;
  localparam int IRQ_EXT_BIT = 1;
  localparam int IRQ_W = 2;

  // Reset values
  localparam logic [3:0] PORT_MODE_RST = 4'h0;
  localparam logic [3:0] ACCESS_RST = 4'h0;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [3:0] SEG_SELECT_RST = 4'h0;
  localparam logic ALT_FUNC_RST = 1'b0;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

endpackage : pei_pkg

// >>> verilog/pei_sync.sv
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes asynchronous pin levels and one system clock.
*/
`timescale 1ns/1ps
module pei_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clock) begin
    if (reset) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Accept a bit once second and third stages agree
  always_ff @(posedge clock) begin
    if (reset) begin
      level_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          level_out[i] <= stage3_reg[i];
        end
      end
    end
  end

endmodule : pei_sync

// >>> verilog/pei_edge.sv
/*
  Edge detector on one synchronised level, rising or falling.
  Assumes the level is already on the system clock.
*/
`timescale 1ns/1ps
module pei_edge (
  input wire logic clock,
  input wire logic reset,
  input wire logic level_in,
  input wire logic falling_sel,
  output logic edge_pulse
);
  logic active;
  logic prev_reg;

  // Normalise so the wanted edge is always low to high
  assign active = falling_sel ? ~level_in : level_in;

  // Previous level and one-cycle pulse
  always_ff @(posedge clock) begin
    if (reset) begin
      prev_reg <= 1'b1;
      edge_pulse <= 1'b0;
    end else begin
      prev_reg <= active;
      edge_pulse <= active & ~prev_reg;
    end
  end

endmodule : pei_edge

// >>> verilog/pei_top.sv
/*
  Port edge interrupt and key-scan access control of a 4-bit MCU.
  Holds the port mode register, the two write-only access registers,
  interrupt status and mask, segment select and alternate function.
  Assumes port data and direction come from the base port logic,
  pins are asynchronous, and the system register port is on clock.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - No new rising group request until all group pins return low.
// - No new falling group request until all group pins return high.
// - Ports C to F selectable as general I/O or LCD segment drivers.
// - Access bit one disconnects pull resistor and blocks port I/O.
// - Access bit zero restores pull resistor and port I/O.
// - Access bits write-only; C D E F in 3..0, A B in 1..0.
// - Pull-high needs enable, direction one, data one; low the reverse.
// - Mode register: pull enable bit 3, pull direction bit 2.
module pei_top #(
  parameter logic [1:0] BOND_OPTION = 2'h0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [pei_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pei_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pei_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [pei_pkg::PIN_W-1:0] pin_in,
  input wire logic [pei_pkg::PIN_W-1:0] port_data,
  input wire logic [pei_pkg::PIN_W-1:0] port_dir,
  output logic [pei_pkg::PIN_W-1:0] pull_high_en,
  output logic [pei_pkg::PIN_W-1:0] pull_low_en,
  output logic [pei_pkg::PIN_W-1:0] pin_read,
  output logic [pei_pkg::NUM_PORTS-1:0] port_io_enable,
  output logic [3:0] seg_select,
  output logic port_group_edge_interrupt,
  output logic external_edge_interrupt,
  output logic irq
);
  import pei_pkg::*;

  // Expand one bit per port to one bit per pin
  function automatic logic [PIN_W-1:0] expand_ports(
    input logic [NUM_PORTS-1:0] per_port
  );
    logic [PIN_W-1:0] result;
    result = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      result[p*PORT_W +: PORT_W] = {PORT_W{per_port[p]}};
    end
    return result;
  endfunction : expand_ports

  // Register state
  logic pull_resistor_enable_reg;
  logic pull_direction_select_reg;
  logic port_c_access_disable_reg;
  logic port_d_access_disable_reg;
  logic port_e_access_disable_reg;
  logic port_f_access_disable_reg;
  logic port_a_access_disable_reg;
  logic port_b_access_disable_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [3:0] seg_select_reg;
  logic alt_func_reg;

  // Decoded strobes
  logic wr_mode;
  logic wr_access_cdef;
  logic wr_access_ab;
  logic wr_status;
  logic wr_mask;
  logic wr_seg;
  logic wr_alt;

  // Internal signals
  logic [NUM_PORTS-1:0] access_disable;
  logic [PIN_W-1:0] access_mask;
  logic [PIN_W-1:0] pin_level;
  logic [2*PORT_W-1:0] group_pins;
  logic group_any_high;
  logic group_all_high;
  logic group_level;
  logic group_edge;
  logic ext_edge;
  logic [IRQ_W-1:0] irq_events;
  logic [PIN_W-1:0] pull_high_next;
  logic [PIN_W-1:0] pull_low_next;
  logic [DATA_W-1:0] rdata_next;

  // Write address decode
  assign wr_mode = reg_wr && (reg_addr == ADDR_PORT_MODE);
  assign wr_access_cdef = reg_wr && (reg_addr == ADDR_ACCESS_CDEF);
  assign wr_access_ab = reg_wr && (reg_addr == ADDR_ACCESS_AB);
  assign wr_status = reg_wr && (reg_addr == ADDR_IRQ_STATUS);
  assign wr_mask = reg_wr && (reg_addr == ADDR_IRQ_MASK);
  assign wr_seg = reg_wr && (reg_addr == ADDR_SEG_SELECT);
  assign wr_alt = reg_wr && (reg_addr == ADDR_ALT_FUNC);

  // Port mode register: pull enable and pull direction
  always_ff @(posedge clock) begin
    if (reset) begin
      pull_resistor_enable_reg <= PORT_MODE_RST[PULL_ENABLE_BIT];
      pull_direction_select_reg <= PORT_MODE_RST[PULL_DIR_BIT];
    end else if (wr_mode) begin
      pull_resistor_enable_reg <= reg_wdata[PULL_ENABLE_BIT];
      pull_direction_select_reg <= reg_wdata[PULL_DIR_BIT];
    end
  end

  // Access register for ports C to F, write-only
  always_ff @(posedge clock) begin
    if (reset) begin
      port_c_access_disable_reg <= ACCESS_RST[ACC_C_BIT];
      port_d_access_disable_reg <= ACCESS_RST[ACC_D_BIT];
      port_e_access_disable_reg <= ACCESS_RST[ACC_E_BIT];
      port_f_access_disable_reg <= ACCESS_RST[ACC_F_BIT];
    end else if (wr_access_cdef) begin
      port_c_access_disable_reg <= reg_wdata[ACC_C_BIT];
      port_d_access_disable_reg <= reg_wdata[ACC_D_BIT];
      port_e_access_disable_reg <= reg_wdata[ACC_E_BIT];
      port_f_access_disable_reg <= reg_wdata[ACC_F_BIT];
    end
  end

  // Access register for ports A and B, write-only
  always_ff @(posedge clock) begin
    if (reset) begin
      port_a_access_disable_reg <= ACCESS_RST[ACC_A_BIT];
      port_b_access_disable_reg <= ACCESS_RST[ACC_B_BIT];
    end else if (wr_access_ab) begin
      port_a_access_disable_reg <= reg_wdata[ACC_A_BIT];
      port_b_access_disable_reg <= reg_wdata[ACC_B_BIT];
    end
  end

  // Segment select for ports C to F, one means LCD segment
  always_ff @(posedge clock) begin
    if (reset) begin
      seg_select_reg <= SEG_SELECT_RST;
    end else if (wr_seg) begin
      seg_select_reg <= reg_wdata;
    end
  end

  // Alternate function flag for ports B and C
  always_ff @(posedge clock) begin
    if (reset) begin
      alt_func_reg <= ALT_FUNC_RST;
    end else if (wr_alt) begin
      alt_func_reg <= reg_wdata[0];
    end
  end

  // Interrupt mask
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_reg <= reg_wdata[IRQ_W-1:0];
    end
  end

  // Per-port access disable in port order A..F
  assign access_disable = {port_f_access_disable_reg,
                           port_e_access_disable_reg,
                           port_d_access_disable_reg,
                           port_c_access_disable_reg,
                           port_b_access_disable_reg,
                           port_a_access_disable_reg};
  assign access_mask = expand_ports(~access_disable);

  // Pin synchroniser for all port pins
  pei_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .clock(clock),
    .reset(reset),
    .async_in(pin_in),
    .level_out(pin_level)
  );

  // Group level: any pin high for rising, all pins high for falling
  assign group_pins = pin_level[PORT_B*PORT_W +: 2*PORT_W];
  assign group_any_high = |group_pins;
  assign group_all_high = &group_pins;
  assign group_level = pull_direction_select_reg ?
                       group_all_high : group_any_high;

  // Group edge detector on the combined level
  pei_edge u_group_edge (
    .clock(clock),
    .reset(reset),
    .level_in(group_level),
    .falling_sel(pull_direction_select_reg),
    .edge_pulse(group_edge)
  );

  // External edge detector on port A bit 0
  pei_edge u_ext_edge (
    .clock(clock),
    .reset(reset),
    .level_in(pin_level[PORT_A*PORT_W]),
    .falling_sel(pull_direction_select_reg),
    .edge_pulse(ext_edge)
  );

  // Interrupt events; group source gated off by alternate function
  assign irq_events[IRQ_GROUP_BIT] = group_edge & ~alt_func_reg;
  assign irq_events[IRQ_EXT_BIT] = ext_edge;

  // Sticky status, write one to clear, a new event wins
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_status_reg <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if (irq_events[i]) begin
          irq_status_reg[i] <= 1'b1;
        end else if (wr_status && reg_wdata[i]) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt line
  always_ff @(posedge clock) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Status bits as level outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      port_group_edge_interrupt <= 1'b0;
      external_edge_interrupt <= 1'b0;
    end else begin
      port_group_edge_interrupt <= irq_status_reg[IRQ_GROUP_BIT];
      external_edge_interrupt <= irq_status_reg[IRQ_EXT_BIT];
    end
  end

  // Pull resistors on input pins only, gated by access
  always_comb begin
    pull_high_next = '0;
    pull_low_next = '0;
    if (pull_resistor_enable_reg) begin
      if (pull_direction_select_reg) begin
        pull_high_next = port_data & ~port_dir & access_mask;
      end else begin
        pull_low_next = ~port_data & ~port_dir & access_mask;
      end
    end
  end

  // Registered pull enables
  always_ff @(posedge clock) begin
    if (reset) begin
      pull_high_en <= '0;
      pull_low_en <= '0;
    end else begin
      pull_high_en <= pull_high_next;
      pull_low_en <= pull_low_next;
    end
  end

  // Pin read data, blocked ports read as zero
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_read <= '0;
    end else begin
      pin_read <= pin_level & access_mask;
    end
  end

  // Port I/O enable per port for the base port logic
  always_ff @(posedge clock) begin
    if (reset) begin
      port_io_enable <= '0;
    end else begin
      port_io_enable <= ~access_disable;
    end
  end

  // Segment select output
  always_ff @(posedge clock) begin
    if (reset) begin
      seg_select <= SEG_SELECT_RST;
    end else begin
      seg_select <= seg_select_reg;
    end
  end

  // Read multiplexer; write-only and unmapped read as zero
  always_comb begin
    rdata_next = '0;
    case (reg_addr)
      ADDR_PORT_MODE: begin
        rdata_next = {pull_resistor_enable_reg,
                      pull_direction_select_reg, BOND_OPTION};
      end
      ADDR_IRQ_STATUS: begin
        rdata_next = {2'h0, irq_status_reg};
      end
      ADDR_IRQ_MASK: begin
        rdata_next = {2'h0, irq_mask_reg};
      end
      ADDR_SEG_SELECT: begin
        rdata_next = seg_select_reg;
      end
      ADDR_ALT_FUNC: begin
        rdata_next = {3'h0, alt_func_reg};
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : pei_top

// >>> dv/pei_chk.sv
/* Port checker of the edge interrupt and key-scan access block.
   Assumes a bind into pei_top and a synchronous active-high reset. */
`timescale 1ns/1ps
module pei_chk #(
  parameter logic [1:0] BOND_OPTION = 2'h0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [pei_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pei_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pei_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [pei_pkg::PIN_W-1:0] pin_in,
  input wire logic [pei_pkg::PIN_W-1:0] port_data,
  input wire logic [pei_pkg::PIN_W-1:0] port_dir,
  input wire logic [pei_pkg::PIN_W-1:0] pull_high_en,
  input wire logic [pei_pkg::PIN_W-1:0] pull_low_en,
  input wire logic [pei_pkg::PIN_W-1:0] pin_read,
  input wire logic [pei_pkg::NUM_PORTS-1:0] port_io_enable,
  input wire logic [3:0] seg_select,
  input wire logic port_group_edge_interrupt,
  input wire logic external_edge_interrupt,
  input wire logic irq
);
  import pei_pkg::*;
  logic [PIN_W-1:0] io_bits;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Port enables spread over their four pins
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      io_bits[4*p +: 4] = {4{port_io_enable[p]}};
    end
  end
  // Read port behaviour
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 4'h0) else $error("read data idle");
  wo_read_a: assert property (
    $past(reg_rd) && ($past(reg_addr) == ADDR_ACCESS_CDEF ||
    $past(reg_addr) == ADDR_ACCESS_AB) |-> reg_rdata == 4'h0)
    else $error("access register readable");
  bond_read_a: assert property (
    $past(reg_rd) && $past(reg_addr) == ADDR_PORT_MODE
    |-> reg_rdata[1:0] == BOND_OPTION) else $error("bond bits wrong");
  // Pull enables follow data and direction
  pull_high_a: assert property (
    (pull_high_en & ~($past(port_data) & ~$past(port_dir))) == '0)
    else $error("pull-high without data one");
  pull_low_a: assert property (
    (pull_low_en & ($past(port_data) | $past(port_dir))) == '0)
    else $error("pull-low without data zero");
  access_off_a: assert property (
    ((pull_high_en | pull_low_en | pin_read) & ~io_bits) == '0)
    else $error("disabled port still active");
  io_change_a: assert property (
    $changed(port_io_enable) |-> $past(reg_wr) || $past(reg_wr, 2) ||
    $past(reset) || $past(reset, 2) || $past(reset, 3))
    else $error("port access changed without write");
  // Interrupt output and sticky status
  irq_src_a: assert property (
    irq |-> port_group_edge_interrupt || external_edge_interrupt)
    else $error("irq without status");
  grp_clear_a: assert property (
    $fell(port_group_edge_interrupt) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("group status lost without clear");
  cover property ($rose(port_group_edge_interrupt));
  cover property ($rose(external_edge_interrupt));
  cover property ($rose(irq));
  cover property (port_io_enable != 6'h3F);
endmodule : pei_chk

bind pei_top pei_chk #(.BOND_OPTION(BOND_OPTION)) chk_u (.*);

// >>> dv/pei_keys.sv
/* Key matrix and edge source model on the port pins.
   Assumes the bench closes switches and the design drives pulls. */
`timescale 1ns/1ps
module pei_keys (
  input wire logic clock,
  input wire logic [pei_pkg::PIN_W-1:0] pull_high_en,
  input wire logic [pei_pkg::PIN_W-1:0] pull_low_en,
  input wire logic [pei_pkg::PIN_W-1:0] press,
  input wire logic [pei_pkg::PIN_W-1:0] drive,
  output logic [pei_pkg::PIN_W-1:0] pin_in
);
  import pei_pkg::*;
  initial pin_in = '0;
  // Closed switch wins, else pull level, else a floating toggle
  always @(posedge clock) begin
    for (int i = 0; i < PIN_W; i++) begin
      if (press[i]) pin_in[i] <= drive[i];
      else if (pull_high_en[i]) pin_in[i] <= 1'b1;
      else if (pull_low_en[i]) pin_in[i] <= 1'b0;
      else pin_in[i] <= ~pin_in[i];
    end
  end
endmodule : pei_keys

// >>> dv/tb_top.sv
/* Self-checking bench of the port edge interrupt block.
   Assumes the key model on the pins and the checker bound in. */
`timescale 1ns/1ps
module tb_top;
  import pei_pkg::*;
  localparam logic [1:0] BOND = 2'h2;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [5:0] reg_addr = '0;
  logic [3:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [23:0] port_data = '0, port_dir = '0, press = '0, drive = '0;
  logic [23:0] pin_in, pull_high_en, pull_low_en, pin_read, dirs, io_pins;
  logic [3:0] reg_rdata, seg_select, cdef, ab;
  logic [5:0] port_io_enable, io;
  logic grp_int, ext_int, irq;
  int err_count = 0;
  int checks_done = 0;
  // Status model: set on each expected event, write one clears
  int exp_st = 0;

  // System clock
  always #5 clock = ~clock;

  pei_top #(.BOND_OPTION(BOND)) dut_u (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .port_data(port_data), .port_dir(port_dir),
    .pull_high_en(pull_high_en), .pull_low_en(pull_low_en),
    .pin_read(pin_read), .port_io_enable(port_io_enable),
    .seg_select(seg_select), .port_group_edge_interrupt(grp_int),
    .external_edge_interrupt(ext_int), .irq(irq));

  pei_keys keys_u (.clock(clock), .pull_high_en(pull_high_en),
    .pull_low_en(pull_low_en), .press(press), .drive(drive),
    .pin_in(pin_in));

  task automatic wrap_up;
    $display("Mismatches %0d in %0d checks", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [23:0] exp,
                     input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [3:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    if (a == ADDR_IRQ_STATUS) exp_st &= ~int'(d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [3:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {20'h0, exp}, {20'h0, reg_rdata});
  endtask : rd

  // Bounded wait of up to 20 cycles for a status flag, then record and check that it came
  task automatic wait_ev(input int b);
    int n = 0;
    while ((b ? ext_int : grp_int) !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n < 20) exp_st |= 1 << b;
    chk("edge event", 24'h1, {23'h0, n < 20});
  endtask : wait_ev

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h8d684833));
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rd(ADDR_PORT_MODE, {2'b00, BOND});
    rd(ADDR_ACCESS_CDEF, 4'h0);
    rd(6'h3F, 4'h0);
    cdef = 4'($urandom);
    wr(ADDR_SEG_SELECT, cdef);
    rd(ADDR_SEG_SELECT, cdef);
    chk("seg_select", {20'h0, cdef}, {20'h0, seg_select});
    dirs = {12'($urandom), 12'h000};
    @(posedge clock);
    port_dir <= dirs;
    wr(ADDR_IRQ_MASK, 4'h1);
    wr(ADDR_PORT_MODE, 4'h8);
    repeat (8) @(posedge clock);
    #1;
    chk("pull_low_en", ~dirs, pull_low_en);
    chk("pull_high_en", 24'h0, pull_high_en);
    wr(ADDR_IRQ_STATUS, 4'h3);
    rd(ADDR_IRQ_STATUS, 4'(exp_st));
    // Rising group edge, held pin blocks the next one
    press <= 24'h10;
    drive <= 24'h10;
    wait_ev(0);
    chk("irq", 24'h1, {23'h0, irq});
    wr(ADDR_IRQ_STATUS, 4'h1);
    press <= 24'h210;
    drive <= 24'h210;
    repeat (15) @(posedge clock);
    rd(ADDR_IRQ_STATUS, 4'(exp_st));
    press <= 24'h0;
    repeat (10) @(posedge clock);
    press <= 24'h80;
    drive <= 24'h80;
    wait_ev(0);
    wr(ADDR_IRQ_STATUS, 4'h1);
    // Rising external edge, masked from irq
    press <= 24'h81;
    drive <= 24'h81;
    wait_ev(1);
    rd(ADDR_IRQ_STATUS, 4'(exp_st));
    chk("irq", 24'h0, {23'h0, irq});
    // Falling edges with pull-high
    @(posedge clock);
    press <= 24'h0;
    port_data <= '1;
    wr(ADDR_PORT_MODE, 4'hC);
    repeat (10) @(posedge clock);
    #1;
    chk("pull_high_en", ~dirs, pull_high_en);
    wr(ADDR_IRQ_STATUS, 4'h3);
    press <= 24'h40;
    drive <= 24'h0;
    wait_ev(0);
    wr(ADDR_IRQ_STATUS, 4'h1);
    press <= 24'h440;
    repeat (15) @(posedge clock);
    rd(ADDR_IRQ_STATUS, 4'(exp_st));
    press <= 24'h441;
    wait_ev(1);
    // Alternate function drops group events
    press <= 24'h0;
    repeat (10) @(posedge clock);
    wr(ADDR_ALT_FUNC, 4'h1);
    wr(ADDR_IRQ_STATUS, 4'h3);
    press <= 24'h40;
    repeat (15) @(posedge clock);
    rd(ADDR_IRQ_STATUS, 4'(exp_st));
    // Key-scan access bits, random and all set
    for (int i = 0; i < 5; i++) begin
      cdef = (i == 0) ? 4'hF : 4'($urandom);
      ab = (i == 0) ? 4'h3 : 4'($urandom) & 4'h3;
      wr(ADDR_ACCESS_CDEF, cdef);
      wr(ADDR_ACCESS_AB, ab);
      io = ~{cdef[0], cdef[1], cdef[2], cdef[3], ab[0], ab[1]};
      repeat (3) @(posedge clock);
      #1;
      for (int p = 0; p < 6; p++) io_pins[4*p +: 4] = {4{io[p]}};
      chk("port_io_enable", {18'h0, io}, {18'h0, port_io_enable});
      chk("pull_high_en", ~dirs & io_pins, pull_high_en);
      chk("pin_read", 24'h0, pin_read & ~io_pins);
    end
    wr(ADDR_ACCESS_CDEF, 4'h0);
    wr(ADDR_ACCESS_AB, 4'h0);
    repeat (3) @(posedge clock);
    #1;
    chk("port_io_enable", 24'h3F, {18'h0, port_io_enable});
    chk("pull_high_en", ~dirs, pull_high_en);
    // Input pins of A to C read back once pulls settle; B2 held low
    repeat (8) @(posedge clock);
    #1;
    chk("pin_read", 24'h000FBF, pin_read & 24'h000FFF);
    wrap_up();
  end
endmodule : tb_top
